// File: pmcs_defs.vh
// Register offsets, field positions and reset values of the mode registers.
// Included by the sequencer and register files of the management register bank.
`ifndef PMCS_DEFS_VH
`define PMCS_DEFS_VH

// ==========================================================
// Addresses
`define PMCS_ADDR_CTRL 5'h00
`define PMCS_ADDR_STAT 5'h01
`define PMCS_ADDR_PAGE 5'h1f
`define PMCS_MAIN_LO 5'h10

// ==========================================================
// Control fields
`define PMCS_C_RESET 15
`define PMCS_C_LOOP 14
`define PMCS_C_SPD_LO 13
`define PMCS_C_ANEN 12
`define PMCS_C_PDN 11
`define PMCS_C_ISO 10
`define PMCS_C_RSTAN 9
`define PMCS_C_DUPLEX 8
`define PMCS_C_COLT 7
`define PMCS_C_SPD_HI 6
`define PMCS_SPD_RST 2'h2
`define PMCS_CTRL_RST 16'h1040

// ==========================================================
// Status fields
`define PMCS_S_ANDONE 5
`define PMCS_S_RFAULT 4
`define PMCS_S_LINK 2
`define PMCS_S_JABBER 1
`define PMCS_STAT_FIXED 16'h7949

`define PMCS_PAGE_RST 16'h0000
`define PMCS_SRST_CYCLES 4

`endif

// File: pmcs_latch.v
// Latching status bit: holds an event until the status register is read.
// Assumes rd_clr is a one-cycle pulse from the register read decode.
`timescale 1ns/100ps
module pmcs_latch #(
	parameter HIGH = 1
) (
	input wire ref_clk,
	input wire rst_n,
	input wire soft_rst,
	input wire cond,
	input wire rd_clr,
	output reg q_r
);
	// ==========================================================
	// Latch
	wire ev = HIGH ? cond : ~cond;
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q_r <= 1'b0;
		end else if (soft_rst) begin
			q_r <= 1'b0;
		end else if (ev) begin
			// Event wins over the read release
			q_r <= 1'b1;
		end else if (rd_clr) begin
			q_r <= 1'b0;
		end
	end
endmodule

// File: pmcs_srst.v
// Software reset sequencer: stretches a requested reset over a fixed count.
// Assumes req is a one-cycle pulse; busy stays high until the count ends.
`timescale 1ns/100ps
`include "pmcs_defs.vh"
module pmcs_srst #(
	parameter CYCLES = `PMCS_SRST_CYCLES
) (
	input wire ref_clk,
	input wire rst_n,
	input wire req,
	output reg busy_r
);
	// ==========================================================
	// Counter
	reg [7:0] cnt_r;
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			busy_r <= 1'b0;
		end else if (req) begin
			cnt_r <= CYCLES[7:0];
			busy_r <= 1'b1;
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
			busy_r <= (cnt_r != 8'h01);
		end else begin
			busy_r <= 1'b0;
		end
	end
endmodule

// File: pmcs_regs.v
// Mode control, mode status and page select registers of the management port.
// Assumes a synchronous single-cycle read/write strobe from the management
// frame decoder; conditions from the media logic are synchronous levels.
//
// Overview of operation
// [RQ1] Addresses 16..31 answer only while page select holds zero; address 31 (page select) always answers here.
// [RQ2] Master treats reserved bits in 16..31 as read-only, undefined.
// [RQ3] Master read-modify-writes registers that hold reserved bits.
// [RQ4] Writes never change reserved bits; their read value may vary.
// [RQ5] Control bit 14 enables loopback at the current speed; resets 0.
// [RQ6] Speed field bits 6 and 13: 10/100/1000/reserved; resets to 1000.
// [RQ7] Control bit 12 enables auto-negotiation; resets 1.
// [RQ8] Control bit 11 powers down and stops in-band status; resets 0.
// [RQ9] Control bit 10 isolates the MAC interface; resets 0.
// [RQ10] Control bit 9 restarts auto-negotiation and clears itself.
// [RQ11] Control bit 8 selects full duplex, also in loopback; resets 0.
// [RQ12] Control bit 7 enables collision test; resets 0.
// [RQ13] Fixed capability bits read as documented, extended status present.
// [RQ14] Status bit 6 reads 1: preamble may be suppressed.
// [RQ15] Status bit 5 shows auto-negotiation complete.
// [RQ16] Status bit 4 latches high on far-end fault until read.
// [RQ17] Status bit 2 shows link up, latching low until read.
// [RQ18] Status bit 1 latches high on jabber until read.
// [RQ19] Reading status releases the latched bits.
// [RQ20] Control bit 15 resets logic and registers, clearing when done.
`timescale 1ns/100ps
`include "pmcs_defs.vh"
module pmcs_regs #(
	parameter SRST_CYCLES = `PMCS_SRST_CYCLES
) (
	input wire ref_clk,
	input wire rst_n,
	input wire reg_rd,
	input wire reg_wr,
	input wire [4:0] reg_addr,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	output reg reg_rvalid,
	input wire an_done,
	input wire far_fault,
	input wire link_up,
	input wire jabber,
	output reg loopback_en,
	output reg [1:0] speed_sel,
	output reg an_enable,
	output reg power_down,
	output reg inband_en,
	output reg mac_isolate,
	output reg an_restart,
	output reg full_duplex,
	output reg col_test,
	output reg soft_reset
);
	// ==========================================================
	// Decode
	reg [15:0] ctrl_r;
	reg [15:0] page_r;
	wire srst_busy;
	reg srst_req;
	wire page_ok = (page_r == 16'h0000);
	// Upper half only reachable on page zero, except the page register itself
	wire addr_ok = (reg_addr < `PMCS_MAIN_LO) || page_ok ||
		(reg_addr == `PMCS_ADDR_PAGE); // RQ1
	wire wr_ctrl = reg_wr && (reg_addr == `PMCS_ADDR_CTRL);
	wire wr_page = reg_wr && (reg_addr == `PMCS_ADDR_PAGE);
	wire rd_stat = reg_rd && (reg_addr == `PMCS_ADDR_STAT);
	// A reset request leaves the fields alone: the media side never
	// sees a one-cycle stray mode before the defaults come back
	wire wr_fields = wr_ctrl && !reg_wdata[`PMCS_C_RESET];

	// ==========================================================
	// Software reset
	pmcs_srst #(.CYCLES(SRST_CYCLES)) u_srst (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.req(srst_req),
		.busy_r(srst_busy)
	);

	always @* begin
		srst_req = wr_ctrl && reg_wdata[`PMCS_C_RESET] && !srst_busy; // RQ20
	end

	// ==========================================================
	// Control and page registers
	reg [15:0] ctrl_nxt;
	always @* begin
		ctrl_nxt = ctrl_r;
		if (wr_fields) begin
			// Reserved low six bits kept as they were
			ctrl_nxt[15:6] = reg_wdata[15:6]; // RQ4
		end
		if (!wr_fields) begin
			ctrl_nxt[`PMCS_C_RSTAN] = 1'b0; // RQ10
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `PMCS_CTRL_RST;
		end else if (srst_busy) begin
			// Defaults held while reset runs, bit 15 reads 1
			ctrl_r <= `PMCS_CTRL_RST | 16'h8000; // RQ20
		end else begin
			ctrl_r <= ctrl_nxt;
			ctrl_r[`PMCS_C_RESET] <= 1'b0; // RQ20
		end
	end

	// Page returns to zero on any reset, so a master that lost track
	// of the page still reaches the main registers afterwards
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			page_r <= `PMCS_PAGE_RST;
		end else if (srst_busy) begin
			page_r <= `PMCS_PAGE_RST;
		end else if (wr_page) begin
			page_r <= reg_wdata; // RQ1
		end
	end

	// ==========================================================
	// Latching status
	wire lat_rf;
	wire lat_jab;
	wire lat_nolink;
	pmcs_latch #(.HIGH(1)) u_rf (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.soft_rst(srst_busy),
		.cond(far_fault),
		.rd_clr(rd_stat),
		.q_r(lat_rf)
	);
	pmcs_latch #(.HIGH(1)) u_jab (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.soft_rst(srst_busy),
		.cond(jabber),
		.rd_clr(rd_stat),
		.q_r(lat_jab)
	);
	pmcs_latch #(.HIGH(0)) u_link (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.soft_rst(srst_busy),
		.cond(link_up),
		.rd_clr(rd_stat),
		.q_r(lat_nolink)
	);

	// Read shows latched state merged with the live condition
	reg [15:0] stat_val;
	always @* begin
		stat_val = `PMCS_STAT_FIXED; // RQ13 RQ14
		stat_val[`PMCS_S_ANDONE] = an_done; // RQ15
		stat_val[`PMCS_S_RFAULT] = lat_rf | far_fault; // RQ16 RQ19
		stat_val[`PMCS_S_LINK] = link_up & ~lat_nolink; // RQ17 RQ19
		stat_val[`PMCS_S_JABBER] = lat_jab | jabber; // RQ18 RQ19
	end

	// ==========================================================
	// Read port
	reg [15:0] rdata_nxt;
	always @* begin
		rdata_nxt = 16'h0000;
		if (addr_ok) begin
			case (reg_addr)
				`PMCS_ADDR_CTRL: rdata_nxt = ctrl_r;
				`PMCS_ADDR_STAT: rdata_nxt = stat_val;
				`PMCS_ADDR_PAGE: rdata_nxt = page_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
		end
	end

	// Data holds between reads, so a slow master may take it late
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt; // RQ1
		end
	end

	// ==========================================================
	// Mode outputs
	// Each output a cycle behind the control register (soft_reset behind the sequencer), one flop apiece
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			loopback_en <= 1'b0;
		end else begin
			loopback_en <= ctrl_r[`PMCS_C_LOOP]; // RQ5
		end
	end

	// Loopback leaves the speed alone: it keeps the current selection
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			speed_sel <= `PMCS_SPD_RST;
		end else begin
			speed_sel <= {ctrl_r[`PMCS_C_SPD_HI],
				ctrl_r[`PMCS_C_SPD_LO]}; // RQ6
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			an_enable <= 1'b1;
		end else begin
			an_enable <= ctrl_r[`PMCS_C_ANEN]; // RQ7
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_down <= 1'b0;
		end else begin
			power_down <= ctrl_r[`PMCS_C_PDN]; // RQ8
		end
	end

	// Same edge as power-down, so in-band status never overlaps it
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			inband_en <= 1'b1;
		end else begin
			inband_en <= ~ctrl_r[`PMCS_C_PDN]; // RQ8
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mac_isolate <= 1'b0;
		end else begin
			mac_isolate <= ctrl_r[`PMCS_C_ISO]; // RQ9
		end
	end

	// One-cycle pulse: the control bit clears itself a cycle earlier
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			an_restart <= 1'b0;
		end else begin
			an_restart <= ctrl_r[`PMCS_C_RSTAN]; // RQ10
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			full_duplex <= 1'b0;
		end else begin
			full_duplex <= ctrl_r[`PMCS_C_DUPLEX]; // RQ11
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			col_test <= 1'b0;
		end else begin
			col_test <= ctrl_r[`PMCS_C_COLT]; // RQ12
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= srst_busy; // RQ20
		end
	end
endmodule

// File: pmcs_chk.sv
// Port checker for the mode register bank.
// Assumes single-cycle strobes from the management side.
`timescale 1ns/100ps
module pmcs_chk (
	input wire ref_clk,
	input wire rst_n,
	input wire reg_rd,
	input wire reg_wr,
	input wire [4:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	input wire reg_rvalid,
	input wire an_done,
	input wire jabber,
	input wire power_down,
	input wire inband_en,
	input wire [1:0] speed_sel,
	input wire an_restart,
	input wire soft_reset
);
	// ====
	// Properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("answer without read");
	a_inband_pdn: assert property (inband_en == !power_down)
		else $error("in-band status active in power-down");
	a_restart_pulse: assert property (an_restart |=> !an_restart)
		else $error("restart not self-clearing");
	a_restart_cause: assert property (an_restart |-> $past(reg_wr, 2)
		&& $past(reg_wdata[9], 2)) else $error("restart without write");
	a_speed_write: assert property (reg_wr && reg_addr == 5'h00
		&& !reg_wdata[15] && !soft_reset ##2 1 |-> speed_sel ==
		{$past(reg_wdata[6], 2), $past(reg_wdata[13], 2)})
		else $error("speed field wrong");
	a_stat_fixed: assert property (reg_rvalid && $past(reg_addr) == 5'h01
		|-> (reg_rdata & 16'hffc9) == 16'h7949) else $error("fixed bits");
	a_andone_bit: assert property (reg_rvalid && $past(reg_addr) == 5'h01
		|-> reg_rdata[5] == $past(an_done)) else $error("an done bit");
	a_jabber_live: assert property (reg_rvalid && $past(reg_addr) == 5'h01
		&& $past(jabber) |-> reg_rdata[1]) else $error("jabber bit");
	a_ctrl_resv: assert property (reg_rvalid && $past(reg_addr) == 5'h00
		|-> reg_rdata[5:0] == 6'h00) else $error("reserved bits");
endmodule
bind pmcs_regs pmcs_chk i_chk (.*);

// File: pmcs_mgr.sv
// Management master model driving the register strobes.
// Assumes the answer one cycle after the read edge.
`timescale 1ns/100ps
module pmcs_mgr (
	input wire ref_clk,
	input wire [15:0] reg_rdata,
	output logic reg_rd = 1'b0,
	output logic reg_wr = 1'b0,
	output logic [4:0] reg_addr = 5'h00,
	output logic [15:0] reg_wdata = 16'h0000
);
	// ====
	// Bus cycles
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge ref_clk);
		#1 reg_wr = 1'b0;
		// Released lines never keep the last value
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge ref_clk);
		#1 reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
	task rmw(input logic [4:0] a, input logic [15:0] m, input logic [15:0] v);
		logic [15:0] t;
		rd(a, t);
		wr(a, (t & ~m) | (v & m));
	endtask
endmodule

// File: phy_mode_control_status_regs_tb.sv
// Self-checking bench for the mode register bank.
// Assumes the master model and the bound checker.
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
miscompares++; $display("CHECK FAILED %0t got %h exp %h", $time, (a), \
(e)); end end
module phy_mode_control_status_regs_tb;
	logic ref_clk, rst_n, an_done, far_fault, link_up, jabber;
	wire reg_rd, reg_wr, reg_rvalid, loopback_en, an_enable, power_down;
	wire inband_en, mac_isolate, an_restart, full_duplex, col_test;
	wire soft_reset;
	wire [1:0] speed_sel;
	wire [4:0] reg_addr;
	wire [15:0] reg_wdata, reg_rdata;
	logic [15:0] d, w;
	int miscompares, checks_done, cycles, n;
	pmcs_regs #(.SRST_CYCLES(2)) i_dut (.*);
	pmcs_mgr i_mgr (.*);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ====
	// Verdict
	task complete_run;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end
	// ====
	// Tests
	initial begin
		{rst_n, an_done, far_fault, link_up, jabber} = 5'h00;
		void'($urandom(42481));
		repeat (10) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		i_mgr.rd(5'h00, d);
		`CHK(d, 16'h1040)
		`CHK({speed_sel, an_enable, inband_en}, 4'hb)
		i_mgr.rd(5'h01, d);
		`CHK(d, 16'h7949)
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			w = (i == 0) ? 16'h7dbf : (i == 1) ? 16'h0000 : $urandom & 16'h7dff;
			if (w[6] & w[13])
				w[6] = 1'b0;
			i_mgr.rmw(5'h00, 16'h7dff, w);
			repeat (2) @(posedge ref_clk);
			#1 `CHK({loopback_en, speed_sel, an_enable, power_down, inband_en,
				mac_isolate, full_duplex, col_test}, {w[14], w[6], w[13],
				w[12:11], ~w[11], w[10], w[8:7]})
			i_mgr.rd(5'h00, d);
			`CHK(d, w & 16'h7dc0)
		end
		$display("test control done");
		i_mgr.wr(5'h00, 16'h0200);
		@(posedge ref_clk);
		#1 `CHK(an_restart, 1'b1)
		i_mgr.rd(5'h00, d);
		`CHK({an_restart, d[9]}, 2'b00)
		i_mgr.wr(5'h1f, 16'h0005);
		i_mgr.rd(5'h1f, d);
		`CHK(d, 16'h0005)
		i_mgr.rd(5'h10, d);
		`CHK(d, 16'h0000)
		i_mgr.wr(5'h1f, 16'h0000);
		$display("test restart page done");
		link_up = 1'b1;
		i_mgr.rd(5'h01, d);
		i_mgr.rd(5'h01, d);
		`CHK(d[2], 1'b1)
		{far_fault, jabber, link_up} = 3'b110;
		@(posedge ref_clk);
		#1 {far_fault, jabber, link_up, an_done} = 4'b0011;
		repeat (2) @(posedge ref_clk);
		i_mgr.rd(5'h01, d);
		`CHK(d & 16'h0036, 16'h0032)
		i_mgr.rd(5'h01, d);
		`CHK(d & 16'h0036, 16'h0024)
		$display("test latch done");
		i_mgr.wr(5'h00, 16'h0100);
		i_mgr.wr(5'h00, 16'h8100);
		for (n = 0; n < 20 && soft_reset !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		`CHK(soft_reset, 1'b1)
		for (n = 0; n < 20 && soft_reset !== 1'b0; n++) begin
			@(posedge ref_clk);
			#1;
		end
		i_mgr.rd(5'h00, d);
		`CHK({d, full_duplex}, {16'h1040, 1'b0})
		$display("test soft reset done");
		complete_run();
	end
endmodule
